// [flash_block_protection.sv]
// flash access control: per-unit protection, fetch/data/debug reads, erase
// assumes requesters hold a request for one cycle and prot settings are static-ish
//
// Behaviour
// - 64 KB, 1 KB blocks erased independently.
// - erased block reads back all ones.
// - protection per 2 KB unit, independent.
// - levels: open, read-only, execute-only.
// - read-only refuses erase and program.
// - execute-only: fetch reads only, no writes.
// - a permitted read answers in one cycle when no higher-priority read shares that cycle.
`include "flash_prot_cfg.svh"
module flash_block_protection
  import flash_prot_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // protection settings, one level per 2 KB unit
  input wire logic prot_set,
  input wire logic [4:0] prot_unit,
  input flash_prot_pkg::prot_level_t prot_level,
  // instruction fetch
  input wire logic fetch_req,
  input wire logic [13:0] fetch_addr,
  output logic fetch_ack_ff,
  output logic [31:0] fetch_data_ff,
  // data read
  input wire logic data_req,
  input wire logic [13:0] data_addr,
  output logic data_ack_ff,
  output logic data_denied_ff,
  output logic [31:0] data_rdata_ff,
  // debugger read
  input wire logic dbg_req,
  input wire logic [13:0] dbg_addr,
  output logic dbg_ack_ff,
  output logic dbg_denied_ff,
  output logic [31:0] dbg_rdata_ff,
  // program
  input wire logic prog_req,
  input wire logic [13:0] prog_addr,
  input wire logic [31:0] prog_data,
  output logic prog_done_ff,
  output logic prog_denied_ff,
  // erase
  input wire logic erase_req,
  input wire logic [5:0] erase_block,
  output logic erase_busy_ff,
  output logic erase_done_ff,
  output logic erase_denied_ff
);
  import flash_prot_pkg::*;

  // ***************************
  // protection table
  // ***************************
  prot_level_t level_ff [0:`FP_NUM_UNITS - 1];

  genvar gi;
  generate
    for (gi = 0; gi < `FP_NUM_UNITS; gi = gi + 1) begin : g_unit
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          level_ff[gi] <= prot_level_t'(`FP_LEVEL_RESET);
        end else if (prot_set && prot_unit == 5'(gi)) begin
          level_ff[gi] <= prot_level;
        end
      end
    end
  endgenerate

  // unit = word address upper bits: two 1 KB blocks per unit
  prot_level_t data_lvl, dbg_lvl, prog_lvl, erase_lvl;
  assign data_lvl = level_ff[data_addr[13:`FP_UNIT_LSB]];
  assign dbg_lvl = level_ff[dbg_addr[13:`FP_UNIT_LSB]];
  assign prog_lvl = level_ff[prog_addr[13:`FP_UNIT_LSB]];
  assign erase_lvl = level_ff[erase_block[5:1]];

  logic data_ok, dbg_ok, prog_ok, erase_ok;
  assign data_ok = (data_lvl != PROT_EXEC_ONLY);
  assign dbg_ok = (dbg_lvl != PROT_EXEC_ONLY);
  assign prog_ok = (prog_lvl == PROT_OPEN);
  assign erase_ok = (erase_lvl == PROT_OPEN);

  // ***************************
  // erase sequencer
  // ***************************
  erase_state_t state_ff;
  logic [5:0] er_blk_ff;
  logic [7:0] er_idx_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (erase_req) begin
            state_ff <= erase_ok ? ST_ERASE : ST_REFUSE;
          end
        end
        ST_ERASE: begin
          if (er_idx_ff == 8'hFF) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        ST_REFUSE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      er_blk_ff <= 6'h00;
      er_idx_ff <= 8'h00;
    end else if (state_ff == ST_IDLE && erase_req) begin
      er_blk_ff <= erase_block;
      er_idx_ff <= 8'h00;
    end else if (state_ff == ST_ERASE) begin
      er_idx_ff <= er_idx_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      erase_busy_ff <= 1'b0;
      erase_done_ff <= 1'b0;
      erase_denied_ff <= 1'b0;
    end else begin
      erase_busy_ff <= (state_ff == ST_IDLE && erase_req && erase_ok) ||
                       (state_ff == ST_ERASE && er_idx_ff != 8'hFF);
      erase_done_ff <= (state_ff == ST_ERASE && er_idx_ff == 8'hFF);
      erase_denied_ff <= (state_ff == ST_IDLE && erase_req && !erase_ok);
    end
  end

  // ***************************
  // array and write gating
  // ***************************
  logic arr_erase, arr_prog;
  logic [13:0] rd_addr;
  logic [31:0] arr_rdata;

  // only one block's words are touched by an erase
  assign arr_erase = (state_ff == ST_ERASE);
  // a permitted program is dropped unanswered during erase: simpler than arbitrating the write port
  assign arr_prog = prog_req && prog_ok && !arr_erase;

  // one read port: fetch first, then data, then debugger
  assign rd_addr = fetch_req ? fetch_addr : (data_req ? data_addr : dbg_addr);

  flash_prot_array u_array (
    .clk(clk),
    .rd_addr(rd_addr),
    .rd_data(arr_rdata),
    .prog_en(arr_prog),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .erase_en(arr_erase),
    .erase_addr({er_blk_ff, er_idx_ff})
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prog_done_ff <= 1'b0;
      prog_denied_ff <= 1'b0;
    end else begin
      prog_done_ff <= arr_prog;
      prog_denied_ff <= prog_req && !prog_ok;
    end
  end

  // ***************************
  // read answers
  // ***************************
  logic data_sel, dbg_sel;
  // one read port, so a lower requester in the same cycle is dropped
  assign data_sel = data_req && !fetch_req;
  assign dbg_sel = dbg_req && !fetch_req && !data_req;

  // answers registered straight off the array read: one cycle, no wait states
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetch_ack_ff <= 1'b0;
      fetch_data_ff <= `FP_WITHHELD_WORD;
      data_ack_ff <= 1'b0;
      data_denied_ff <= 1'b0;
      data_rdata_ff <= `FP_WITHHELD_WORD;
      dbg_ack_ff <= 1'b0;
      dbg_denied_ff <= 1'b0;
      dbg_rdata_ff <= `FP_WITHHELD_WORD;
    end else begin
      fetch_ack_ff <= fetch_req;
      fetch_data_ff <= fetch_req ? arr_rdata : `FP_WITHHELD_WORD;
      data_ack_ff <= data_sel && data_ok;
      data_denied_ff <= data_sel && !data_ok;
      data_rdata_ff <= (data_sel && data_ok) ? arr_rdata : `FP_WITHHELD_WORD;
      dbg_ack_ff <= dbg_sel && dbg_ok;
      dbg_denied_ff <= dbg_sel && !dbg_ok;
      dbg_rdata_ff <= (dbg_sel && dbg_ok) ? arr_rdata : `FP_WITHHELD_WORD;
    end
  end
endmodule : flash_block_protection

// [flash_block_protection_props.sv]
// checker: read answers, hiding, erase timing
// assumes binding to flash_block_protection
module flash_block_protection_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // reads
  input wire logic fetch_req,
  input wire logic fetch_ack_ff,
  input wire logic data_req,
  input wire logic data_ack_ff,
  input wire logic data_denied_ff,
  input wire logic [31:0] data_rdata_ff,
  input wire logic dbg_req,
  input wire logic dbg_ack_ff,
  input wire logic dbg_denied_ff,
  input wire logic [31:0] dbg_rdata_ff,
  // writes
  input wire logic prog_req,
  input wire logic prog_done_ff,
  input wire logic prog_denied_ff,
  input wire logic erase_req,
  input wire logic erase_busy_ff,
  input wire logic erase_done_ff,
  input wire logic erase_denied_ff
);
  // *****
  // properties
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence erase_go;
    erase_req && !erase_busy_ff ##1 erase_busy_ff;
  endsequence
  chk_fetch_ack: assert property (fetch_req |=> fetch_ack_ff) else $error("fetch unanswered");
  chk_data_ans: assert property (data_req && !fetch_req |=> data_ack_ff ^ data_denied_ff) else $error("data unanswered");
  chk_dbg_ans: assert property (dbg_req && !fetch_req && !data_req |=> dbg_ack_ff ^ dbg_denied_ff) else $error("dbg unanswered");
  chk_data_hide: assert property (data_denied_ff |-> data_rdata_ff == 32'h0 && !data_ack_ff) else $error("data leaked");
  chk_dbg_hide: assert property (dbg_denied_ff |-> dbg_rdata_ff == 32'h0 && !dbg_ack_ff) else $error("dbg leaked");
  chk_erase_len: assert property (erase_go |-> ##256 erase_done_ff) else $error("erase length");
  chk_erase_refuse: assert property (erase_denied_ff |-> !erase_busy_ff ##1 !erase_busy_ff) else $error("refused erase ran");
  chk_prog_ans: assert property (prog_req && !erase_req && !erase_busy_ff && !erase_done_ff |=> prog_done_ff ^ prog_denied_ff) else $error("prog unanswered");
endmodule : flash_block_protection_props
bind flash_block_protection flash_block_protection_props i_props (.*);

// [flash_prot_array.sv]
// flash word array: combinational read, word program, block erase
// assumes callers have already applied protection checks
`include "flash_prot_cfg.svh"
module flash_prot_array
  import flash_prot_pkg::*;
(
  // clock
  input wire logic clk,
  // read
  input wire logic [13:0] rd_addr,
  output logic [31:0] rd_data,
  // program
  input wire logic prog_en,
  input wire logic [13:0] prog_addr,
  input wire logic [31:0] prog_data,
  // erase, one word per cycle
  input wire logic erase_en,
  input wire logic [13:0] erase_addr
);
  logic [31:0] mem [0:(1 << `FP_WORD_ADDR_W) - 1];

  // plain read: the caller's answer flop makes the single cycle
  assign rd_data = mem[rd_addr];

  // program only clears bits, like real flash cells
  always_ff @(posedge clk) begin
    if (erase_en) begin
      mem[erase_addr] <= `FP_ERASED_WORD;
    end else if (prog_en) begin
      mem[prog_addr] <= mem[prog_addr] & prog_data;
    end
  end
endmodule : flash_prot_array

// [flash_prot_cfg.svh]
// flash protection constants: geometry, encodings, fill and reset values
// assumes inclusion by the package and the design modules only
`ifndef FLASH_PROT_CFG_SVH
`define FLASH_PROT_CFG_SVH

// ***************************
// geometry
// ***************************
`define FP_FLASH_BYTES 65536
`define FP_ERASE_BLOCK_BYTES 1024
`define FP_PROT_UNIT_BYTES 2048
`define FP_NUM_BLOCKS 64
`define FP_NUM_UNITS 32
`define FP_WORD_ADDR_W 14
`define FP_BLOCK_LSB 8
`define FP_UNIT_LSB 9
`define FP_WORDS_PER_BLOCK 256

// ***************************
// encodings and values
// ***************************
`define FP_ERASED_WORD 32'hFFFFFFFF
`define FP_WITHHELD_WORD 32'h00000000
`define FP_LEVEL_RESET 2'h0

`endif

// [flash_prot_pkg.sv]
// flash protection types
// assumes flash_prot_cfg.svh is on the include path
package flash_prot_pkg;
  `include "flash_prot_cfg.svh"

  typedef enum logic [1:0] {
    PROT_OPEN = 2'h0,
    PROT_READ_ONLY = 2'h1,
    PROT_EXEC_ONLY = 2'h2
  } prot_level_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ERASE = 4'h2,
    ST_DONE = 4'h4,
    ST_REFUSE = 4'h8
  } erase_state_t;
endpackage : flash_prot_pkg

// [flash_requester.sv]
// requester model: fetch, data and debug reads
// assumes one read at a time, driven 1 ns after a rising edge
module flash_requester (
  // clock
  input wire logic clk,
  // read requests
  output logic fetch_req,
  output logic [13:0] fetch_addr,
  output logic data_req,
  output logic [13:0] data_addr,
  output logic dbg_req,
  output logic [13:0] dbg_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // read driver
  // *****
  initial {fetch_req, data_req, dbg_req, fetch_addr, data_addr, dbg_addr} = '0;
  task automatic rd(input logic [1:0] p, input logic [13:0] a);
    @(posedge clk) #1;
    {fetch_req, data_req, dbg_req} = {p == 2'h0, p == 2'h1, p == 2'h2};
    {fetch_addr, data_addr, dbg_addr} = {3{a}};
    @(posedge clk) #1;
    {fetch_req, data_req, dbg_req} = 3'h0;
    // released address shows inverse, never a stale copy
    {fetch_addr, data_addr, dbg_addr} = {3{~a}};
  endtask : rd
endmodule : flash_requester

// [tb_top.sv]
// testbench: erase, program, protection levels, reads
// assumes the requester model drives all read paths
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_prot_pkg::*;
  // *****
  // signals and helpers
  // *****
  typedef struct {logic [1:0] p; logic [13:0] a; logic [31:0] d; logic den;} row_t;
  logic clk, reset_n, prot_set, prog_req, erase_req, fetch_req, data_req, dbg_req;
  logic [4:0] prot_unit;
  prot_level_t prot_level;
  logic [13:0] prog_addr, fetch_addr, data_addr, dbg_addr;
  logic [31:0] prog_data, fetch_data_ff, data_rdata_ff, dbg_rdata_ff;
  logic [5:0] erase_block;
  logic fetch_ack_ff, data_ack_ff, data_denied_ff, dbg_ack_ff, dbg_denied_ff;
  logic prog_done_ff, prog_denied_ff, erase_busy_ff, erase_done_ff, erase_denied_ff;
  int bad_count = 0, n_tests = 0, cyc = 0;
  row_t rows[8] = '{'{0, 14'h0000, 32'h12345678, 0}, '{1, 14'h0000, 32'h12345678, 0},
    '{2, 14'h0000, 32'h12345678, 0}, '{1, 14'h0100, 32'hFFFFFFFF, 0}, '{0, 14'h0200, 32'hA5A5A5A5, 0},
    '{1, 14'h0200, 32'h0, 1}, '{2, 14'h0200, 32'h0, 1}, '{2, 14'h00FF, 32'hFFFFFFFF, 0}};
  flash_block_protection i_dut (.*);
  flash_requester i_req (.*);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic prot(input logic [4:0] u, input prot_level_t l);
    @(posedge clk) #1;
    {prot_set, prot_unit, prot_level} = {1'b1, u, l};
    @(posedge clk) #1;
    prot_set = 0;
  endtask : prot
  task automatic prog(input logic [13:0] a, input logic [31:0] d, input logic den);
    @(posedge clk) #1;
    {prog_req, prog_addr, prog_data} = {1'b1, a, d};
    @(posedge clk) #1;
    prog_req = 0;
    chk({prog_done_ff, prog_denied_ff}, {!den, den});
  endtask : prog
  task automatic erase(input logic [5:0] b, input logic den);
    int n;
    @(posedge clk) #1;
    {erase_req, erase_block} = {1'b1, b};
    @(posedge clk) #1;
    erase_req = 0;
    chk(erase_denied_ff, den);
    n = 0;
    while (!den && erase_done_ff !== 1'b1 && n < 300) begin
      @(posedge clk) #1;
      n++;
    end
    if (!den) chk(n, 256);
  endtask : erase
  task automatic rd(input logic [1:0] p, input logic [13:0] a, input logic [31:0] d, input logic den);
    i_req.rd(p, a);
    chk(p == 0 ? {fetch_ack_ff, 1'b0, fetch_data_ff} : p == 1 ? {data_ack_ff, data_denied_ff, data_rdata_ff} :
      {dbg_ack_ff, dbg_denied_ff, dbg_rdata_ff}, {!den, den, d});
  endtask : rd
  // bound well above four erases of some 260 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      complete_run();
    end
  end
  // *****
  // sequence
  // *****
  initial begin
    {reset_n, prot_set, prog_req, erase_req, prot_unit, prog_addr, prog_data, erase_block} = '0;
    prot_level = PROT_OPEN;
    repeat (12) @(posedge clk);
    #1 reset_n = 1;
    chk({erase_busy_ff, data_ack_ff, prog_done_ff, erase_denied_ff}, 0);
    erase(0, 0);
    erase(1, 0);
    erase(2, 0);
    prog(14'h0000, 32'h12345678, 0);
    erase(1, 0);
    prot(0, PROT_READ_ONLY);
    prog(14'h0200, 32'hA5A5A5A5, 0);
    prot(1, PROT_EXEC_ONLY);
    foreach (rows[i]) rd(rows[i].p, rows[i].a, rows[i].d, rows[i].den);
    prog(14'h0000, 32'h0, 1);
    erase(1, 1);
    prog(14'h0201, 32'h0, 1);
    erase(2, 1);
    rd(1, 14'h0000, 32'h12345678, 0);
    rd(0, 14'h0201, 32'hFFFFFFFF, 0);
    // mid-run reset: answers clear, levels reopen, array keeps its words
    @(posedge clk) #1 reset_n = 0;
    @(posedge clk) #1 reset_n = 1;
    chk({fetch_ack_ff, data_ack_ff, data_denied_ff, dbg_ack_ff, prog_done_ff, erase_busy_ff}, 0);
    rd(1, 14'h0200, 32'hA5A5A5A5, 0);
    complete_run();
  end
endmodule : tb_top
